// ### hdl/dds_ctrl_top.sv
// Functional notes
// - Output frequency is a binary fraction of the master clock only.
// - One serial bit is captured on each falling shift clock edge while frame sync is low.
// - Sixteen serial bits are assembled into one word.
// - Frame sync low starts a new word.
// - Accumulator step comes from frequency word zero or one.
// - Frequency choice comes from the pin or a control bit.
// - The frequency choice pin is sampled on rising master clock edges.
// - Pin changes at an edge may switch a cycle early or late.
// - Four phase offsets; the chosen one is added before the cosine table.
// - Phase offset choice comes from the two phase pins.
// - Alternatively phase offset choice comes from two control bits.
// - Phase pins sampled on rising edges; edge changes shift by a cycle.
// - 32-bit accumulator adds the selected word every master clock cycle with clk_en high.
// - 12-bit offsets add to the accumulator's most significant bits.
// - Switching frequency words keeps accumulator phase continuous.
`timescale 1ns/1ps
module dds_ctrl_top
    import dds_ctrl_pkg::*;
#(
    parameter int ACC_WIDTH = ACC_W,
    parameter int OFS_WIDTH = PHASE_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_shift_clock,
    input wire logic serial_input_line,
    input wire logic word_frame_sync,
    input wire logic freq_reg_choice,
    input wire logic phase_choice_lsb,
    input wire logic phase_choice_msb,
    output logic [OFS_WIDTH-1:0] cos_table_addr,
    output logic active_freq_sel,
    output logic [1:0] active_phase_sel
);
    initial begin
        if (ACC_WIDTH != 32 || OFS_WIDTH != 12) begin
            $error("dds_ctrl_top: only a 32-bit accumulator and 12-bit offsets");
        end
    end

    apb_state_t state, next_state;
    logic [CTRL_W-1:0] ctrl, next_ctrl;
    logic [ACC_WIDTH-1:0] freq_word_zero, next_freq_word_zero;
    logic [ACC_WIDTH-1:0] freq_word_one, next_freq_word_one;
    logic [ACC_WIDTH-1:0] acc, next_acc, active_step;
    logic [OFS_WIDTH-1:0] acc_msb_d, next_acc_msb_d, next_cos_table_addr;
    logic [OFS_WIDTH-1:0] offset_rd, reg_rd;
    logic [2:0] pin_s1, pin_s2;
    logic next_active_freq_sel;
    logic [1:0] next_active_phase_sel;
    logic [DATA_W-1:0] next_prdata, read_mux;
    logic next_pready, next_pslverr;
    logic [WORD_W-1:0] rx_word, last_word, next_last_word;
    logic rx_done;
    logic [7:0] word_count, next_word_count;
    logic bus_take, bus_write, addr_ok, phase_hit;
    logic [1:0] phase_slot;

    serial_word_rx #(
        .WIDTH(WORD_W)
    ) u_rx (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .serial_shift_clock(serial_shift_clock),
        .serial_input_line(serial_input_line),
        .word_frame_sync(word_frame_sync),
        .word_data(rx_word),
        .word_done(rx_done)
    );

    phase_offset_bank #(
        .DEPTH(PHASE_REGS),
        .WIDTH(OFS_WIDTH)
    ) u_bank (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .wr_en(bus_write && phase_hit),
        .wr_addr(phase_slot),
        .wr_data(pwdata[OFS_WIDTH-1:0]),
        .rd_addr_a(active_phase_sel),
        .rd_data_a(offset_rd),
        .rd_addr_b(phase_slot),
        .rd_data_b(reg_rd)
    );

    // Bus slave: access phase waits two cycles, the second one for the bank read,
    // then pready is high for one cycle
    always_comb begin
        phase_hit = paddr >= OFS_PHASE0 && paddr <= OFS_PHASE3 && paddr[1:0] == 2'b00;
        phase_slot = 2'((paddr - OFS_PHASE0) >> 2);
        addr_ok = phase_hit;
        unique case (paddr)
            OFS_CTRL, OFS_FREQ_ZERO, OFS_FREQ_ONE, OFS_WORD, OFS_STATUS, OFS_ACC: addr_ok = 1'b1;
            default: ;
        endcase
        bus_take = state == ST_ANSWER && psel && penable;
        bus_write = bus_take && pwrite && addr_ok;
        read_mux = '0;
        if (phase_hit) begin
            read_mux = DATA_W'(reg_rd);
        end
        unique case (paddr)
            OFS_CTRL: read_mux = DATA_W'(ctrl);
            OFS_FREQ_ZERO: read_mux = freq_word_zero;
            OFS_FREQ_ONE: read_mux = freq_word_one;
            OFS_WORD: read_mux = DATA_W'(last_word);
            OFS_STATUS: read_mux = DATA_W'({word_count, active_freq_sel, active_phase_sel});
            OFS_ACC: read_mux = acc;
            default: ;
        endcase
        next_state = state;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        next_prdata = prdata;
        unique case (state)
            ST_IDLE: begin
                if (psel && penable) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                next_state = ST_ANSWER;
                next_pready = 1'b1;
                next_pslverr = ~addr_ok;
                next_prdata = (pwrite || !addr_ok) ? '0 : read_mux;
            end
            ST_ANSWER: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (clk_en) begin
            state <= next_state;
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    always_comb begin
        next_ctrl = ctrl;
        next_freq_word_zero = freq_word_zero;
        next_freq_word_one = freq_word_one;
        if (bus_write && paddr == OFS_CTRL) begin
            next_ctrl = pwdata[CTRL_W-1:0];
        end
        if (bus_write && paddr == OFS_FREQ_ZERO) begin
            next_freq_word_zero = pwdata;
        end
        if (bus_write && paddr == OFS_FREQ_ONE) begin
            next_freq_word_one = pwdata;
        end
        next_last_word = rx_done ? rx_word : last_word;
        next_word_count = rx_done ? word_count + 8'd1 : word_count;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl <= CTRL_RESET;
            freq_word_zero <= FREQ_RESET;
            freq_word_one <= FREQ_RESET;
            last_word <= WORD_RESET;
            word_count <= 8'h00;
        end else if (clk_en) begin
            ctrl <= next_ctrl;
            freq_word_zero <= next_freq_word_zero;
            freq_word_one <= next_freq_word_one;
            last_word <= next_last_word;
            word_count <= next_word_count;
        end
    end

    // Selection pins: two-stage sync, then the chosen source is registered.
    // A pin moving at an edge lands one cycle either way.
    always_comb begin
        if (ctrl[CTRL_FREQ_SRC]) begin
            next_active_freq_sel = ctrl[CTRL_FREQ_BIT];
        end else begin
            next_active_freq_sel = pin_s2[2];
        end
        if (ctrl[CTRL_PHASE_SRC]) begin
            next_active_phase_sel = {ctrl[CTRL_PHASE_MSB], ctrl[CTRL_PHASE_LSB]};
        end else begin
            next_active_phase_sel = pin_s2[1:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_s1 <= 3'h0;
            pin_s2 <= 3'h0;
            active_freq_sel <= 1'b0;
            active_phase_sel <= 2'b00;
        end else if (clk_en) begin
            pin_s1 <= {freq_reg_choice, phase_choice_msb, phase_choice_lsb};
            pin_s2 <= pin_s1;
            active_freq_sel <= next_active_freq_sel;
            active_phase_sel <= next_active_phase_sel;
        end
    end

    // Accumulator is never cleared on a switch, so phase stays continuous
    always_comb begin
        active_step = active_freq_sel ? freq_word_one : freq_word_zero;
        next_acc = acc + active_step;
        next_acc_msb_d = acc[ACC_WIDTH-1 -: OFS_WIDTH];
        next_cos_table_addr = acc_msb_d + offset_rd;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            acc <= '0;
            acc_msb_d <= '0;
            cos_table_addr <= '0;
        end else if (clk_en) begin
            acc <= next_acc;
            acc_msb_d <= next_acc_msb_d;
            cos_table_addr <= next_cos_table_addr;
        end
    end

    // Datapath and clock-enable checks
    acc_step_a: assert property (@(posedge sys_clk) disable iff (rst)
        $past(clk_en) |-> acc == $past(acc) + $past(active_step))
        else $error("accumulator did not add the step");

    freq_zero_step_a: assert property (@(posedge sys_clk) disable iff (rst)
        $past(clk_en) && !$past(active_freq_sel) |-> acc == $past(acc) + $past(freq_word_zero))
        else $error("word zero not added while selected");

    freq_one_step_a: assert property (@(posedge sys_clk) disable iff (rst)
        $past(clk_en) && $past(active_freq_sel) |-> acc == $past(acc) + $past(freq_word_one))
        else $error("word one not added while selected");

    acc_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(clk_en) |-> $stable(acc))
        else $error("accumulator moved while disabled");

    msb_pipe_a: assert property (@(posedge sys_clk) disable iff (rst)
        $past(clk_en) |-> acc_msb_d == $past(acc[ACC_WIDTH-1 -: OFS_WIDTH]))
        else $error("accumulator msbs not taken");

    cos_sum_a: assert property (@(posedge sys_clk) disable iff (rst)
        $past(clk_en) |-> cos_table_addr == $past(acc_msb_d) + $past(offset_rd))
        else $error("cosine address is not msbs plus offset");

    // Selection path checks
    freq_pin_a: assert property (@(posedge sys_clk) disable iff (rst)
        $past(clk_en) && !$past(ctrl[CTRL_FREQ_SRC]) |-> active_freq_sel == $past(pin_s2[2]))
        else $error("frequency pin not followed");

    freq_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
        $past(clk_en) && $past(ctrl[CTRL_FREQ_SRC]) |-> active_freq_sel == $past(ctrl[CTRL_FREQ_BIT]))
        else $error("frequency bit not followed");

    phase_pin_a: assert property (@(posedge sys_clk) disable iff (rst)
        $past(clk_en) && !$past(ctrl[CTRL_PHASE_SRC]) |-> active_phase_sel == $past(pin_s2[1:0]))
        else $error("phase pins not followed");

    phase_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
        $past(clk_en) && $past(ctrl[CTRL_PHASE_SRC])
        |-> active_phase_sel == {$past(ctrl[CTRL_PHASE_MSB]), $past(ctrl[CTRL_PHASE_LSB])})
        else $error("phase bits not followed");

    sel_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(clk_en) |-> $stable(active_freq_sel) && $stable(active_phase_sel))
        else $error("selection moved while disabled");

    sync_pins_a: assert property (@(posedge sys_clk) disable iff (rst)
        $past(clk_en) |-> pin_s2 == $past(pin_s1))
        else $error("pin synchroniser skipped a stage");

    // Bus slave checks
    ready_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
        pready && clk_en |=> !pready)
        else $error("pready held more than one cycle");

    answer_gap_a: assert property (@(posedge sys_clk) disable iff (rst)
        pready && clk_en |=> state == ST_IDLE)
        else $error("slave not idle after answer");

    ready_state_a: assert property (@(posedge sys_clk) disable iff (rst)
        pready |-> state == ST_ANSWER)
        else $error("pready outside answer state");

    err_ready_a: assert property (@(posedge sys_clk) disable iff (rst)
        pslverr |-> pready)
        else $error("error flag without pready");

    write_data_a: assert property (@(posedge sys_clk) disable iff (rst)
        pready && pwrite |-> prdata == '0)
        else $error("read data not zero on a write");

    err_data_a: assert property (@(posedge sys_clk) disable iff (rst)
        pslverr |-> prdata == '0)
        else $error("read data not zero on an error");

    // Register write and serial word checks
    freq_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && bus_write && paddr == OFS_FREQ_ZERO |=> freq_word_zero == $past(pwdata))
        else $error("frequency word zero write lost");

    freq_one_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && bus_write && paddr == OFS_FREQ_ONE |=> freq_word_one == $past(pwdata))
        else $error("frequency word one write lost");

    ctrl_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && bus_write && paddr == OFS_CTRL |=> ctrl == $past(pwdata[CTRL_W-1:0]))
        else $error("control write lost");

    bad_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && bus_take && pwrite && !addr_ok
        |=> $stable(ctrl) && $stable(freq_word_zero) && $stable(freq_word_one))
        else $error("unmapped write changed a register");

    word_store_a: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && rx_done |=> last_word == $past(rx_word))
        else $error("received word not stored");

    word_count_a: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && rx_done |=> word_count == $past(word_count) + 8'd1)
        else $error("word count not advanced");
endmodule : dds_ctrl_top

// ### hdl/dds_ctrl_pkg.sv
package dds_ctrl_pkg;
    localparam int ACC_W = 32;
    localparam int PHASE_W = 12;
    localparam int WORD_W = 16;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int PHASE_REGS = 4;
    localparam int SYNC_STAGES = 2;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FREQ_ZERO = 8'h04;
    localparam logic [7:0] OFS_FREQ_ONE = 8'h08;
    localparam logic [7:0] OFS_PHASE0 = 8'h0C;
    localparam logic [7:0] OFS_PHASE3 = 8'h18;
    localparam logic [7:0] OFS_WORD = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_ACC = 8'h24;
    localparam int CTRL_FREQ_SRC = 0;
    localparam int CTRL_FREQ_BIT = 1;
    localparam int CTRL_PHASE_SRC = 2;
    localparam int CTRL_PHASE_LSB = 3;
    localparam int CTRL_PHASE_MSB = 4;
    localparam int CTRL_W = 5;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [31:0] FREQ_RESET = 32'h0000_0000;
    localparam logic [11:0] PHASE_RESET = 12'h000;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_ANSWER = 3'b100
    } apb_state_t;
endpackage : dds_ctrl_pkg

// ### hdl/serial_word_rx.sv
`timescale 1ns/1ps
module serial_word_rx
    import dds_ctrl_pkg::*;
#(
    parameter int WIDTH = WORD_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic serial_shift_clock,
    input wire logic serial_input_line,
    input wire logic word_frame_sync,
    output logic [WIDTH-1:0] word_data,
    output logic word_done
);
    initial begin
        if (WIDTH < 2 || WIDTH > 32) $error("serial_word_rx: WIDTH out of range");
    end

    // Order in vectors: clock, data, frame
    logic [2:0] pin_s1, pin_s2;
    logic sclk_prev, next_sclk_prev;
    logic [WIDTH-1:0] shift, next_shift, next_word_data;
    logic [4:0] bit_count, next_bit_count;
    logic next_word_done;
    logic fall;

    always_comb begin
        fall = sclk_prev & ~pin_s2[2];
        next_sclk_prev = pin_s2[2];
        next_shift = shift;
        next_bit_count = bit_count;
        next_word_data = word_data;
        next_word_done = 1'b0;
        if (pin_s2[0]) begin
            next_bit_count = 5'd0;
        end else if (fall) begin
            next_shift = {shift[WIDTH-2:0], pin_s2[1]};
            if (bit_count == 5'(WIDTH - 1)) begin
                next_word_data = {shift[WIDTH-2:0], pin_s2[1]};
                next_word_done = 1'b1;
                next_bit_count = 5'd0;
            end else begin
                next_bit_count = bit_count + 5'd1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_s1 <= 3'h7;
            pin_s2 <= 3'h7;
            sclk_prev <= 1'b1;
            shift <= '0;
            bit_count <= 5'd0;
            word_data <= '0;
            word_done <= 1'b0;
        end else if (clk_en) begin
            pin_s1 <= {serial_shift_clock, serial_input_line, word_frame_sync};
            pin_s2 <= pin_s1;
            sclk_prev <= next_sclk_prev;
            shift <= next_shift;
            bit_count <= next_bit_count;
            word_data <= next_word_data;
            word_done <= next_word_done;
        end
    end

    word_len_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(word_done) |-> $past(bit_count) == 5'(WIDTH - 1))
        else $error("word completed after wrong bit count");
    frame_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
        $past(clk_en) && $past(pin_s2[0]) |-> bit_count == 5'd0)
        else $error("bit count not cleared while frame high");
endmodule : serial_word_rx

// ### hdl/phase_offset_bank.sv
`timescale 1ns/1ps
module phase_offset_bank
    import dds_ctrl_pkg::*;
#(
    parameter int DEPTH = PHASE_REGS,
    parameter int WIDTH = PHASE_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic wr_en,
    input wire logic [1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [1:0] rd_addr_a,
    output logic [WIDTH-1:0] rd_data_a,
    input wire logic [1:0] rd_addr_b,
    output logic [WIDTH-1:0] rd_data_b
);
    initial begin
        if (DEPTH != 4 || WIDTH < 1) $error("phase_offset_bank: unsupported size");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_rd_a, next_rd_b;

    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        logic [WIDTH-1:0] next_entry;
        always_comb begin
            next_entry = mem[i];
            if (wr_en && wr_addr == 2'(i)) begin
                next_entry = wr_data;
            end
        end
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                mem[i] <= WIDTH'(PHASE_RESET);
            end else if (clk_en) begin
                mem[i] <= next_entry;
            end
        end
    end

    always_comb begin
        next_rd_a = mem[rd_addr_a];
        next_rd_b = mem[rd_addr_b];
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_data_a <= '0;
            rd_data_b <= '0;
        end else if (clk_en) begin
            rd_data_a <= next_rd_a;
            rd_data_b <= next_rd_b;
        end
    end
endmodule : phase_offset_bank

// ### bench/serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model (
    input wire logic sys_clk,
    output logic serial_shift_clock,
    output logic serial_input_line,
    output logic word_frame_sync,
    output logic freq_reg_choice,
    output logic phase_choice_lsb,
    output logic phase_choice_msb
);
    initial begin
        serial_shift_clock = 1'b1;
        serial_input_line = 1'b0;
        word_frame_sync = 1'b1;
        {freq_reg_choice, phase_choice_msb, phase_choice_lsb} = 3'b000;
    end

    task automatic ticks(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : ticks

    // Sends the first n bits of w, msb first; shift clock idles high outside frames
    task automatic send_bits(input logic [15:0] w, input int n);
        word_frame_sync = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            ticks(4);
            serial_input_line = w[i];
            ticks(4);
            serial_shift_clock = 1'b0;
            ticks(4);
            serial_shift_clock = 1'b1;
        end
        ticks(4);
        word_frame_sync = 1'b1;
        serial_input_line = ~serial_input_line;
        ticks(8);
    endtask : send_bits

    // Pins move on falling edges so they are steady at every rising edge
    task automatic set_pins(input logic f, input logic [1:0] p);
        ticks(1);
        freq_reg_choice = f;
        {phase_choice_msb, phase_choice_lsb} = p;
    endtask : set_pins
endmodule : serial_host_model

// ### bench/dds_serial_and_register_select_tb.sv
`timescale 1ns/1ps
module dds_serial_and_register_select_tb
    import dds_ctrl_pkg::*;
;
    logic sys_clk, rst, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    logic sck, sdi, frame, fpin, plsb, pmsb, active_freq_sel;
    logic [11:0] cos_table_addr;
    logic [1:0] active_phase_sel;
    logic [31:0] rd, a0, a1, d1, d2;
    logic er;
    logic [11:0] ofs [4] = '{12'h7FF, 12'h801, 12'hABC, 12'h0F0};
    int fails, check_count;

    dds_ctrl_top uut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_shift_clock(sck), .serial_input_line(sdi), .word_frame_sync(frame),
        .freq_reg_choice(fpin), .phase_choice_lsb(plsb), .phase_choice_msb(pmsb),
        .cos_table_addr(cos_table_addr), .active_freq_sel(active_freq_sel),
        .active_phase_sel(active_phase_sel));

    serial_host_model host (.sys_clk(sys_clk), .serial_shift_clock(sck), .serial_input_line(sdi),
        .word_frame_sync(frame), .freq_reg_choice(fpin), .phase_choice_lsb(plsb),
        .phase_choice_msb(pmsb));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fails++;
            wrap_up();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Selection reaches the outputs a few edges after the pin or bit moves
    task automatic wait_sel(input logic f, input logic [1:0] p);
        int n;
        n = 0;
        while ({active_freq_sel, active_phase_sel} !== {f, p} && n < 8) begin
            @(posedge sys_clk);
            n++;
        end
        chk("selection", {29'h0, active_freq_sel, active_phase_sel}, {29'h0, f, p});
    endtask : wait_sel

    task automatic reg_map();
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status reset", rd, 32'h0000_0000);
        apb(1'b1, OFS_CTRL, 32'hFFFF_FFFF);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl bits", rd, 32'h0000_001F);
        chk("ctrl no err", {31'h0, er}, 32'h0000_0000);
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b0, 8'h28, 32'h0);
        chk("unmapped err", {31'h0, er}, 32'h0000_0001);
        apb(1'b1, 8'h28, 32'hFFFF_FFFF);
        chk("unmapped write err", {31'h0, er}, 32'h0000_0001);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl kept", rd, 32'h0000_0000);
    endtask : reg_map

    task automatic serial_words();
        host.send_bits(16'hA5C3, 16);
        apb(1'b0, OFS_WORD, 32'h0);
        chk("word one", rd, 32'h0000_A5C3);
        host.send_bits(16'h3C00, 5);
        host.send_bits(16'h1E69, 16);
        apb(1'b1, OFS_WORD, 32'h0000_FFFF);
        apb(1'b0, OFS_WORD, 32'h0);
        chk("word after abort", rd, 32'h0000_1E69);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("word count", {24'h0, rd[10:3]}, 32'h0000_0002);
    endtask : serial_words

    task automatic freq_select();
        host.set_pins(1'b1, 2'd0);
        wait_sel(1'b1, 2'd0);
        host.set_pins(1'b0, 2'd0);
        wait_sel(1'b0, 2'd0);
        apb(1'b1, OFS_CTRL, 32'h0000_0003);
        wait_sel(1'b1, 2'd0);
        apb(1'b1, OFS_CTRL, 32'h0000_0000);
        wait_sel(1'b0, 2'd0);
    endtask : freq_select

    task automatic phase_select();
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 8'(OFS_PHASE0 + 4 * k), {20'hF_FFFF, ofs[k]});
            apb(1'b0, 8'(OFS_PHASE0 + 4 * k), 32'h0);
            chk("offset width", rd, {20'h0, ofs[k]});
        end
        for (int k = 0; k < 4; k++) begin
            host.set_pins(1'b0, 2'(k));
            wait_sel(1'b0, 2'(k));
            repeat (2) @(posedge sys_clk);
            chk("offset add", {20'h0, cos_table_addr}, {20'h0, ofs[k]});
        end
        host.set_pins(1'b0, 2'd0);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, OFS_CTRL, 32'h4 | (k << 3));
            wait_sel(1'b0, 2'(k));
        end
        apb(1'b1, OFS_CTRL, 32'h0);
    endtask : phase_select

    task automatic accum();
        apb(1'b1, OFS_FREQ_ZERO, 32'h1000_0000);
        apb(1'b1, OFS_FREQ_ONE, 32'h3000_0000);
        apb(1'b0, OFS_ACC, 32'h0);
        a0 = rd;
        apb(1'b0, OFS_ACC, 32'h0);
        d1 = rd - a0;
        host.set_pins(1'b1, 2'd0);
        wait_sel(1'b1, 2'd0);
        apb(1'b0, OFS_ACC, 32'h0);
        a0 = rd;
        apb(1'b0, OFS_ACC, 32'h0);
        d2 = rd - a0;
        chk("step ratio", d2, 3 * d1);
        chk("step multiple", {31'h0, d1 != 0 && d1[11:0] == 12'h000}, 32'h1);
        apb(1'b1, OFS_FREQ_ONE, 32'h0);
        apb(1'b1, OFS_FREQ_ZERO, 32'h0);
        apb(1'b0, OFS_ACC, 32'h0);
        a1 = rd;
        repeat (2) @(posedge sys_clk);
        chk("msb offset", {20'h0, cos_table_addr}, {20'h0, a1[31:20] + ofs[0]});
        host.set_pins(1'b0, 2'd0);
        wait_sel(1'b0, 2'd0);
        apb(1'b0, OFS_ACC, 32'h0);
        chk("phase kept", rd, a1);
    endtask : accum

    // Ten disabled edges must not add; a mid-run reset clears the step
    task automatic freeze_reset();
        apb(1'b1, OFS_FREQ_ZERO, 32'h0000_0100);
        apb(1'b0, OFS_ACC, 32'h0);
        a0 = rd;
        clk_en <= 1'b0;
        repeat (10) @(posedge sys_clk);
        clk_en <= 1'b1;
        apb(1'b0, OFS_ACC, 32'h0);
        chk("frozen step", rd - a0, 32'h0000_0500);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        apb(1'b0, OFS_ACC, 32'h0);
        chk("acc after reset", rd, 32'h0000_0000);
    endtask : freeze_reset

    initial begin
        rst = 1'b1;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        fails = 0;
        check_count = 0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        reg_map();
        serial_words();
        freq_select();
        phase_select();
        accum();
        freeze_reset();
        wrap_up();
    end
endmodule : dds_serial_and_register_select_tb
